// [logic/tx_link_consts.svh]
/*
 * offsets, field positions, reset values and timing counts of the transmit
 * data-link buffer and count control.
 * assumes: included by bare name from the control module, the checker and the testbench.
 */
`ifndef TX_LINK_CONSTS_SVH
`define TX_LINK_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define TXL_ADDR_W           8
`define TXL_OFS_BUFCOUNT     8'h00
`define TXL_OFS_CONTROL      8'h04
`define TXL_OFS_STATUS       8'h08

// ****************************************************************
// field positions
// ****************************************************************
`define TXL_SEL_BIT          7
`define TXL_CNT_MSB          6
`define TXL_CTL_MOS_BIT      0
`define TXL_CTL_FCS_BIT      1
`define TXL_CTL_STOP_BIT     2
`define TXL_STA_BUSY_BIT     0
`define TXL_STA_ACT_BIT      1
`define TXL_STA_PEND_BIT     2

// ****************************************************************
// reset values
// ****************************************************************
`define TXL_RST_COUNT        7'h00
`define TXL_RST_SEL          1'h0
`define TXL_RST_CTL          3'h0

// ****************************************************************
// check sequence and timing
// ****************************************************************
`define TXL_CRC_INIT         16'hFFFF
`define TXL_CRC_POLY         16'h8408
`define TXL_MEM_LAT          1

`endif

// [logic/tx_link_pkg.sv]
/*
 * types of the transmit data-link buffer and count control.
 * assumes: the consts header carries every number.
 */
`default_nettype none

package tx_link_pkg;

  // ****************************************************************
  // sequencer states, gray along idle-read-push-fcs-done
  // ****************************************************************
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_read = 3'h1,
    st_push = 3'h3,
    st_fcs0 = 3'h2,
    st_fcs1 = 3'h6,
    st_done = 3'h7
  } tx_state_t;

endpackage : tx_link_pkg

`default_nettype wire

// [logic/tx_link_buffer_count_control.sv]
/*
 * transmit data-link controller three: buffer select/availability, byte
 * count, octet sequencer with optional check sequence, two-entry output
 * buffer, apb register slave.
 * assumes: the two message buffers live outside and answer a read one
 * clock after buf_rd_en with data held until the next read; the link
 * side drains octets with valid/ready.
 */
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "tx_link_consts.svh"
`default_nettype none

module tx_link_buffer_count_control #(
  parameter int COUNT_W = 7,
  parameter int DATA_W  = 8,
  parameter int BOS_LEN = 2
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`TXL_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // message buffer read port
  output logic                        buf_rd_en,
  output logic                        buf_rd_sel,
  output logic      [COUNT_W-1:0]     buf_rd_addr,
  input  wire logic [DATA_W-1:0]      buf_rd_data,
  // outbound octet stream
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output logic      [DATA_W-1:0]      tx_data,
  output logic                        tx_last,
  // events
  output logic                        tx_end_of_transfer_irq
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (COUNT_W != 7) begin : g_bad_count
    $error("count field must be seven bits");
  end
  if (DATA_W != 8) begin : g_bad_data
    $error("octet path must be eight bits");
  end
  if (BOS_LEN < 1 || BOS_LEN > 127) begin : g_bad_bos
    $error("bit-oriented message length out of range");
  end

  localparam logic [COUNT_W-1:0] BOS_LAST = COUNT_W'(BOS_LEN - 1);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `TXL_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_step

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [COUNT_W-1:0]     count_q, count_d;
  logic                   mos_q, mos_d;
  logic                   fcs_en_q, fcs_en_d;
  logic                   stop_q, stop_d;
  logic                   last_sel_q, last_sel_d;
  logic                   pend_q, pend_d;
  logic                   pend_buf_q, pend_buf_d;

  // sequencer state
  tx_link_pkg::tx_state_t state_q, state_d;
  logic                   act_buf_q, act_buf_d;
  logic                   run_mos_q, run_mos_d;
  logic                   run_fcs_q, run_fcs_d;
  logic [COUNT_W-1:0]     len_q, len_d;
  logic [COUNT_W-1:0]     idx_q, idx_d;
  logic [COUNT_W-1:0]     rep_q, rep_d;
  logic [15:0]            crc_q, crc_d;
  logic                   eot_q, eot_d;

  // output buffer
  logic [DATA_W:0]        fifo_q [2];
  logic [DATA_W:0]        fifo_d [2];
  logic                   wptr_q, wptr_d, rptr_q, rptr_d;
  logic [1:0]             fcnt_q, fcnt_d;

  logic                   busy;
  logic                   avail_sel;
  logic                   wr_acc, rd_acc;
  logic                   start_now;
  logic                   push;
  logic [DATA_W:0]        push_word;
  logic                   in_ready;
  logic                   pop;

  assign busy      = (state_q != tx_link_pkg::st_idle);
  assign avail_sel = busy ? ~act_buf_q : last_sel_q;
  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign in_ready  = (fcnt_q != 2'h2);
  assign pop       = tx_valid && tx_ready;

  // ****************************************************************
  // apb slave: zero wait states, error on unmapped addresses
  // ****************************************************************
  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h0;
    unique case (paddr)
      `TXL_OFS_BUFCOUNT: prdata = {24'h0, avail_sel, count_q};
      `TXL_OFS_CONTROL:  prdata = {29'h0, stop_q, fcs_en_q, mos_q};
      `TXL_OFS_STATUS:   prdata = {29'h0, pend_q, act_buf_q, busy};
      default:           pslverr = psel && penable;
    endcase
    if (!rd_acc) begin
      prdata = 32'h0;
    end
  end

  // ****************************************************************
  // register writes and start requests
  // ****************************************************************
  always_comb begin
    count_d    = count_q;
    mos_d      = mos_q;
    fcs_en_d   = fcs_en_q;
    stop_d     = stop_q;
    last_sel_d = last_sel_q;
    pend_d     = pend_q;
    pend_buf_d = pend_buf_q;
    start_now  = 1'b0;
    if (wr_acc && paddr == `TXL_OFS_CONTROL) begin
      mos_d    = pwdata[`TXL_CTL_MOS_BIT];
      fcs_en_d = pwdata[`TXL_CTL_FCS_BIT];
      stop_d   = pwdata[`TXL_CTL_STOP_BIT];
    end
    if (wr_acc && paddr == `TXL_OFS_BUFCOUNT) begin
      count_d = pwdata[`TXL_CNT_MSB:0];
      if (!busy) begin
        start_now  = 1'b1;
        last_sel_d = ~pwdata[`TXL_SEL_BIT];
      end else if (pwdata[`TXL_SEL_BIT] != act_buf_q) begin
        pend_d     = 1'b1;
        pend_buf_d = pwdata[`TXL_SEL_BIT];
      end
      // a write naming the buffer in use still loads the count but queues no start
    end
    if (state_q == tx_link_pkg::st_idle && pend_q) begin
      pend_d     = 1'b0;
      last_sel_d = ~pend_buf_q;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q    <= `TXL_RST_COUNT;
      last_sel_q <= `TXL_RST_SEL;
      {stop_q, fcs_en_q, mos_q} <= `TXL_RST_CTL;
      pend_q     <= 1'b0;
      pend_buf_q <= 1'b0;
    end else begin
      count_q    <= count_d;
      last_sel_q <= last_sel_d;
      mos_q      <= mos_d;
      fcs_en_q   <= fcs_en_d;
      stop_q     <= stop_d;
      pend_q     <= pend_d;
      pend_buf_q <= pend_buf_d;
    end
  end

  // ****************************************************************
  // octet sequencer
  // ****************************************************************
  always_comb begin
    state_d   = state_q;
    act_buf_d = act_buf_q;
    run_mos_d = run_mos_q;
    run_fcs_d = run_fcs_q;
    len_d     = len_q;
    idx_d     = idx_q;
    rep_d     = rep_q;
    crc_d     = crc_q;
    eot_d     = 1'b0;
    push      = 1'b0;
    push_word = '0;
    buf_rd_en = 1'b0;
    unique case (state_q)
      tx_link_pkg::st_idle: begin
        if (start_now || pend_q) begin
          act_buf_d = start_now ? pwdata[`TXL_SEL_BIT] : pend_buf_q;
          run_mos_d = mos_q;
          run_fcs_d = mos_q && fcs_en_q;
          len_d     = mos_q ? count_d : BOS_LAST;
          rep_d     = count_d;
          idx_d     = '0;
          crc_d     = `TXL_CRC_INIT;
          if (mos_q && count_d == '0) begin
            state_d = run_fcs_d ? tx_link_pkg::st_fcs0 : tx_link_pkg::st_done;
          end else begin
            state_d = tx_link_pkg::st_read;
          end
        end
      end
      tx_link_pkg::st_read: begin
        buf_rd_en = 1'b1;
        state_d   = tx_link_pkg::st_push;
      end
      tx_link_pkg::st_push: begin
        if (in_ready) begin
          push = 1'b1;
          // frame-end marker on the last header/payload octet when no check sequence follows
          push_word = {run_mos_q ? (idx_q == len_q - 1'b1) && !run_fcs_q
                                 : (idx_q == len_q), buf_rd_data};
          crc_d = crc_step(crc_q, buf_rd_data);
          idx_d = idx_q + 1'b1;
          state_d = tx_link_pkg::st_read;
          if (run_mos_q && idx_q == len_q - 1'b1) begin
            state_d = run_fcs_q ? tx_link_pkg::st_fcs0 : tx_link_pkg::st_done;
          end else if (!run_mos_q && idx_q == len_q) begin
            idx_d = '0;
            if (stop_q) begin
              state_d = tx_link_pkg::st_done;
            end else if (rep_q == '0) begin
              state_d = tx_link_pkg::st_read;
            end else if (rep_q == COUNT_W'(1)) begin
              state_d = tx_link_pkg::st_done;
            end else begin
              rep_d = rep_q - 1'b1;
            end
          end
        end
      end
      tx_link_pkg::st_fcs0: begin
        if (in_ready) begin
          push      = 1'b1;
          push_word = {1'b0, ~crc_q[7:0]};
          state_d   = tx_link_pkg::st_fcs1;
        end
      end
      tx_link_pkg::st_fcs1: begin
        if (in_ready) begin
          push      = 1'b1;
          push_word = {1'b1, ~crc_q[15:8]};
          state_d   = tx_link_pkg::st_done;
        end
      end
      tx_link_pkg::st_done: begin
        eot_d   = 1'b1;
        state_d = tx_link_pkg::st_idle;
      end
      default: begin
        state_d = tx_link_pkg::st_idle;
      end
    endcase
  end

  assign buf_rd_sel  = act_buf_q;
  assign buf_rd_addr = idx_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q   <= tx_link_pkg::st_idle;
      act_buf_q <= 1'b0;
      run_mos_q <= 1'b0;
      run_fcs_q <= 1'b0;
      len_q     <= '0;
      idx_q     <= '0;
      rep_q     <= '0;
      crc_q     <= `TXL_CRC_INIT;
      eot_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      act_buf_q <= act_buf_d;
      run_mos_q <= run_mos_d;
      run_fcs_q <= run_fcs_d;
      len_q     <= len_d;
      idx_q     <= idx_d;
      rep_q     <= rep_d;
      crc_q     <= crc_d;
      eot_q     <= eot_d;
    end
  end

  assign tx_end_of_transfer_irq = eot_q;

  // ****************************************************************
  // two-entry output buffer: a stalled link holds the sequencer
  // ****************************************************************
  always_comb begin
    fifo_d = fifo_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    fcnt_d = fcnt_q;
    if (push) begin
      fifo_d[wptr_q] = push_word;
      wptr_d         = ~wptr_q;
    end
    if (pop) begin
      rptr_d = ~rptr_q;
    end
    if (push && !pop) begin
      fcnt_d = fcnt_q + 2'h1;
    end else if (pop && !push) begin
      fcnt_d = fcnt_q - 2'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      wptr_q    <= 1'b0;
      rptr_q    <= 1'b0;
      fcnt_q    <= 2'h0;
    end else begin
      fifo_q <= fifo_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      fcnt_q <= fcnt_d;
    end
  end

  assign tx_valid = (fcnt_q != 2'h0);
  assign tx_data  = fifo_q[rptr_q][DATA_W-1:0];
  assign tx_last  = fifo_q[rptr_q][DATA_W];

endmodule : tx_link_buffer_count_control

`default_nettype wire

// [sim/tx_link_checker.sv]
/*
 * checker: timing and sequencing assertions on the control block's ports.
 * assumes: bound to every instance of tx_link_buffer_count_control.
 */
`timescale 1ns/1ns
`include "tx_link_consts.svh"
`default_nettype none
module tx_link_checker #(
  parameter int COUNT_W = 7,
  parameter int DATA_W  = 8,
  parameter int BOS_LEN = 2
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   resetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`TXL_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // buffer read port
  input wire logic                   buf_rd_en,
  input wire logic                   buf_rd_sel,
  input wire logic [COUNT_W-1:0]     buf_rd_addr,
  input wire logic [DATA_W-1:0]      buf_rd_data,
  // stream and event
  input wire logic                   tx_valid,
  input wire logic                   tx_ready,
  input wire logic [DATA_W-1:0]      tx_data,
  input wire logic                   tx_last,
  input wire logic                   tx_end_of_transfer_irq
);
  logic               busy_q, busy_d, mode_q, mode_d, wr_cnt;
  logic [COUNT_W-1:0] cnt_q, cnt_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // shadow of mode, count and busy
  // ****************************************************************
  // busy runs from the first buffer read to the end pulse
  assign wr_cnt = psel && penable && pwrite && paddr == `TXL_OFS_BUFCOUNT;
  always_comb begin
    busy_d = tx_end_of_transfer_irq ? 1'b0 : (buf_rd_en ? 1'b1 : busy_q);
    mode_d = (psel && penable && pwrite && paddr == `TXL_OFS_CONTROL) ? pwdata[0] : mode_q;
    cnt_d  = (wr_cnt && !busy_q) ? pwdata[COUNT_W-1:0] : cnt_q;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      mode_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      busy_q <= busy_d;
      mode_q <= mode_d;
      cnt_q  <= cnt_d;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_start;
    wr_cnt && pwdata[6:0] != 7'h00 && !busy_q && !tx_valid |=> buf_rd_en && buf_rd_sel == $past(pwdata[7]);
  endproperty
  a_start: assert property (p_start) else $error("start read wrong buffer or late");
  property p_avail; psel && penable && !pwrite && paddr == 8'h00 && busy_q |-> prdata[7] == !buf_rd_sel; endproperty
  a_avail: assert property (p_avail) else $error("select bit shows busy buffer");
  property p_bos_len; buf_rd_en && !mode_q |-> buf_rd_addr < BOS_LEN; endproperty
  a_bos_len: assert property (p_bos_len) else $error("repetition read past message");
  property p_mos_len; buf_rd_en && mode_q |-> buf_rd_addr < cnt_q; endproperty
  a_mos_len: assert property (p_mos_len) else $error("frame read past count");
  property p_rd_gap; buf_rd_en |=> !buf_rd_en; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("reads back to back");
  property p_eot; tx_end_of_transfer_irq |=> !tx_end_of_transfer_irq; endproperty
  a_eot: assert property (p_eot) else $error("end pulse too long");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
  a_hold: assert property (p_hold) else $error("octet lost under stall");
endmodule : tx_link_checker
bind tx_link_buffer_count_control tx_link_checker #(.COUNT_W(COUNT_W), .DATA_W(DATA_W), .BOS_LEN(BOS_LEN)) chk_i (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .buf_rd_en(buf_rd_en), .buf_rd_sel(buf_rd_sel), .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
  .tx_end_of_transfer_irq(tx_end_of_transfer_irq));
`default_nettype wire

// [sim/tx_link_partner.sv]
/*
 * partner: the two message buffers and the link that drains octets.
 * assumes: buffer octet at index i of buffer s is {s, i}.
 */
`timescale 1ns/1ns
`default_nettype none
module tx_link_partner #(
  parameter int COUNT_W = 7,
  parameter int DATA_W  = 8
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               resetn,
  // link pacing, 1 accepts one octet in four
  input  wire logic               slow,
  // buffer read port
  input  wire logic               buf_rd_en,
  input  wire logic               buf_rd_sel,
  input  wire logic [COUNT_W-1:0] buf_rd_addr,
  output logic      [DATA_W-1:0]  buf_rd_data,
  // link
  output logic                    tx_ready
);
  logic [1:0] ph_q;
  // header octets sit at the low indexes like any payload octet
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buf_rd_data <= '0;
      ph_q        <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (buf_rd_en) begin
        buf_rd_data <= DATA_W'({buf_rd_sel, buf_rd_addr});
      end
    end
  end
  assign tx_ready = !slow || ph_q == 2'h3;
endmodule : tx_link_partner
`default_nettype wire

// [sim/tb_tx_link_buffer_count_control.sv]
/*
 * testbench: apb master, link partner, frame and repetition scenarios.
 * assumes: zero-wait apb slave; checker bound in its own file.
 */
`timescale 1ns/1ns
`include "tx_link_consts.svh"
`default_nettype none
module tb_tx_link_buffer_count_control;
  localparam int BLEN = 2;
  logic clock = 1'b0, resetn = 1'b0, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, buf_rd_data, tx_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, buf_rd_en, buf_rd_sel, tx_valid, tx_ready, tx_last, tx_end_of_transfer_irq, err;
  logic [6:0] buf_rd_addr;
  logic [7:0] q_d[$];
  logic       q_l[$];
  int error_cnt = 0, comparisons = 0, eot_cnt = 0;
  always #5 clock = ~clock;
  tx_link_buffer_count_control #(.COUNT_W(7), .DATA_W(8), .BOS_LEN(BLEN)) DUT (.clock, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .buf_rd_en, .buf_rd_sel, .buf_rd_addr, .buf_rd_data,
    .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_end_of_transfer_irq);
  tx_link_partner #(.COUNT_W(7), .DATA_W(8)) far_i (.clock, .resetn, .slow, .buf_rd_en, .buf_rd_sel,
    .buf_rd_addr, .buf_rd_data, .tx_ready);
  // ****************************************************************
  // monitor and helpers
  // ****************************************************************
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      q_d.push_back(tx_data);
      q_l.push_back(tx_last);
    end
    if (tx_end_of_transfer_irq === 1'b1) eot_cnt++;
  end
  task complete_run;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 16) begin error_cnt++; complete_run(); end
  endtask : apb
  task wait_for(input int oct, input int eot);
    for (int k = 0; k < 4000 && (q_d.size() < oct || eot_cnt < eot); k++) @(posedge clock);
    if (q_d.size() < oct || eot_cnt < eot) begin error_cnt++; complete_run(); end
    repeat (8) @(posedge clock);
  endtask : wait_for
  function automatic logic [15:0] crc_of(input logic sel, input int cnt);
    logic [15:0] c;
    c = `TXL_CRC_INIT;
    for (int i = 0; i < cnt; i++) begin
      c ^= {8'h00, sel, 7'(i)};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `TXL_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc_of
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    apb(1'b0, `TXL_OFS_BUFCOUNT, 32'h0); chk("bufcount", 32'h0, rd);
    apb(1'b0, `TXL_OFS_CONTROL, 32'h0); chk("control", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0); chk("unmapped", 32'h1, err);
  endtask : t_reset
  task t_mos(input logic sel, input logic [6:0] cnt, input logic fcs, input logic sl);
    int e0, n;
    slow <= sl;
    apb(1'b1, `TXL_OFS_CONTROL, {30'h0, fcs, 1'b1});
    q_d.delete(); q_l.delete(); e0 = eot_cnt; n = cnt + (fcs ? 2 : 0);
    apb(1'b1, `TXL_OFS_BUFCOUNT, {24'h0, sel, cnt});
    apb(1'b0, `TXL_OFS_BUFCOUNT, 32'h0); chk("next_buffer", !sel, rd[7]);
    wait_for(n, e0 + 1);
    chk("octets", n, q_d.size());
    chk("eot", e0 + 1, eot_cnt);
    for (int i = 0; i < cnt; i++) chk("data", {sel, 7'(i)}, q_d[i]);
    if (fcs) chk("fcs", 16'(~crc_of(sel, cnt)), {q_d[cnt+1], q_d[cnt]});
    for (int i = 0; i < n; i++) chk("last", i == n - 1, q_l[i]);
    apb(1'b0, `TXL_OFS_BUFCOUNT, 32'h0); chk("released", !sel, rd[7]);
    apb(1'b0, `TXL_OFS_STATUS, 32'h0); chk("idle", 32'h0, rd[0]);
    slow <= 1'b0;
  endtask : t_mos
  task t_bos(input logic sel, input logic [6:0] cnt);
    int e0;
    apb(1'b1, `TXL_OFS_CONTROL, 32'h2);
    q_d.delete(); q_l.delete(); e0 = eot_cnt;
    apb(1'b1, `TXL_OFS_BUFCOUNT, {24'h0, sel, cnt});
    wait_for(cnt * BLEN, e0 + 1);
    chk("reps", cnt * BLEN, q_d.size());
    chk("eot", e0 + 1, eot_cnt);
    for (int i = 0; i < cnt * BLEN; i++) chk("data", {sel, 7'(i % BLEN)}, q_d[i]);
    for (int i = 0; i < cnt * BLEN; i++) chk("last", i % BLEN == BLEN - 1, q_l[i]);
  endtask : t_bos
  // second frame queued on the other buffer while the first is still read out
  task t_pend;
    int e0;
    apb(1'b1, `TXL_OFS_CONTROL, 32'h1);
    q_d.delete(); q_l.delete(); e0 = eot_cnt;
    apb(1'b1, `TXL_OFS_BUFCOUNT, 32'h03);
    apb(1'b1, `TXL_OFS_BUFCOUNT, 32'h82);
    apb(1'b0, `TXL_OFS_STATUS, 32'h0); chk("pending", 32'h5, rd);
    wait_for(5, e0 + 2);
    chk("pend_octets", 5, q_d.size());
    chk("pend_eot", e0 + 2, eot_cnt);
    for (int i = 0; i < 5; i++) chk("pend_data", (i < 3) ? {1'b0, 7'(i)} : {1'b1, 7'(i - 3)}, q_d[i]);
    for (int i = 0; i < 5; i++) chk("pend_last", i == 2 || i == 4, q_l[i]);
    apb(1'b0, `TXL_OFS_BUFCOUNT, 32'h0); chk("pend_released", 32'h0, rd[7]);
  endtask : t_pend
  task t_forever;
    int e0;
    slow <= 1'b1;
    apb(1'b1, `TXL_OFS_CONTROL, 32'h0);
    q_d.delete(); q_l.delete(); e0 = eot_cnt;
    apb(1'b1, `TXL_OFS_BUFCOUNT, 32'h80);
    wait_for(6 * BLEN, 0);
    chk("no_end", e0, eot_cnt);
    // software pointing at the buffer in use: must not start a second run
    apb(1'b1, `TXL_OFS_BUFCOUNT, 32'h85);
    apb(1'b1, `TXL_OFS_CONTROL, 32'h4);
    wait_for(0, e0 + 1);
    repeat (40) @(posedge clock);
    chk("one_end", e0 + 1, eot_cnt);
    chk("whole_reps", 0, q_d.size() % BLEN);
    apb(1'b1, `TXL_OFS_CONTROL, 32'h0);
    slow <= 1'b0;
  endtask : t_forever
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_mos(1'b0, 7'h01, 1'b0, 1'b0);
    t_mos(1'b1, 7'h05, 1'b1, 1'b1);
    t_mos(1'b0, 7'h00, 1'b1, 1'b0);
    t_mos(1'b1, 7'h7F, 1'b1, 1'b0);
    t_bos(1'b1, 7'h03);
    t_bos(1'b0, 7'h01);
    t_pend();
    t_forever();
    complete_run();
  end
endmodule : tb_tx_link_buffer_count_control
`default_nettype wire
